/* File: bench/flash_host_model.sv */
// Host controller model: chip select, serial clock and lane drive
`timescale 1ns/100ps
module flash_host_model (
  output logic cs_n,
  output logic sclk,
  output logic [3:0] host_out,
  output logic [3:0] host_oe,
  input wire logic [3:0] lanes
);
  realtime half = 24.0; // Half serial period; raised for a slow host

  // Idle: deselected, clock parked low, lanes released
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    host_out = 4'h0;
    host_oe = 4'h0;
  end

  // Open a frame; clock stays still outside frames
  task automatic start();
    #(half);
    cs_n = 1'b0;
    #(half);
  endtask

  // Close the frame; long gap lets opcode-only commands land
  task automatic stop();
    #(half);
    cs_n = 1'b1;
    host_oe = 4'h0;
    #(4 * half);
  endtask

  // Shift nclk clocks on w lanes, top bits first; w of 0 releases lanes
  task automatic send(input logic [31:0] val, input int nclk, input int w);
    logic [31:0] sh;
    sh = val << (32 - nclk * w);
    host_oe = (w == 4) ? 4'hF : (w == 1) ? 4'h1 : 4'h0;
    for (int i = 0; i < nclk; i++) begin
      // Change while clock is low, device samples on the rise
      host_out = (w == 4) ? sh[31:28] : {3'b000, sh[31]};
      sh = sh << w;
      #(half);
      sclk = 1'b1;
      #(half);
      sclk = 1'b0;
    end
  endtask

  // Sample just before each fall, where the device output has settled
  task automatic recv(input int nbytes, input int w, output logic [31:0] got);
    got = '0;
    host_oe = 4'h0;
    repeat (nbytes * 8 / w) begin
      #(half);
      sclk = 1'b1;
      #(half);
      case (w)
        1: got = {got[30:0], lanes[1]};
        2: got = {got[29:0], lanes[1:0]};
        default: got = {got[27:0], lanes};
      endcase
      sclk = 1'b0;
    end
  endtask
endmodule // flash_host_model

/* File: bench/serial_flash_read_addressing_tb.sv */
// Self-checking bench for the flash read and addressing decoder
`timescale 1ns/100ps
module serial_flash_read_addressing_tb
  import flash_cmd_pkg::*;
;
  logic clk = 1'b0; // 200 MHz system clock
  logic nrst = 1'b0;
  logic quad = 1'b0;
  logic busy = 1'b0;
  logic soft_rst = 1'b0;
  logic cs_n, sclk, write_enable_latch, address_width_select, wrap, oe_seen, wrap_seen;
  logic [3:0] host_out, host_oe, io_out, io_oe;
  logic [3:0] float_pat = 4'h5; // Released lanes read a fixed 0101 pattern
  wire [3:0] lanes;
  logic [7:0] uab, array_data, ua;
  array_req_t areq;
  logic [31:0] a, ea, got;
  int abits, dum;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] ops [6] = '{OP_READ, OP_FAST, OP_DUAL,
                          OP_READ_W32, OP_FAST_W32, OP_DUAL_W32};

  // Array contents: address bytes 0, 2 and 3 shape the byte
  function automatic logic [7:0] mem_byte(input logic [31:0] x);
    return x[7:0] ^ x[23:16] ^ {x[30:24], x[31]};
  endfunction

  // Expected stream of nb bytes from a rising address
  function automatic logic [31:0] exp_bytes(input logic [31:0] x, input int nb);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < nb; i++) r = {r[23:0], mem_byte(x + i)};
    return r;
  endfunction

  always #2.5 clk = ~clk;
  assign array_data = mem_byte(areq.addr);
  // Wire level: device drive wins, then host, else fixed pattern
  assign lanes = (io_oe & io_out) | (~io_oe & host_oe & host_out)
               | (~io_oe & ~host_oe & float_pat);

  flash_read_decoder dut (
    .SYS_CLK(clk), .NRST(nrst), .CS_N(cs_n), .SCLK(sclk), .IO_IN(lanes),
    .IO_OUT(io_out), .IO_OE(io_oe), .QUAD_COMMAND_MODE(quad), .BUSY(busy),
    .SOFT_RESET(soft_rst), .WRITE_ENABLE_LATCH(write_enable_latch),
    .ADDRESS_WIDTH_SELECT(address_width_select), .UPPER_ADDRESS_BYTE(uab),
    .ARRAY_REQ(areq), .ARRAY_DATA(array_data), .WRAP_BURST_START(wrap)
  );
  flash_host_model host (
    .cs_n(cs_n), .sclk(sclk), .host_out(host_out), .host_oe(host_oe),
    .lanes(lanes)
  );

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // Opcode frame with an optional data byte
  task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int nb);
    int cw;
    cw = quad ? 4 : 1;
    host.start();
    host.send({24'h0, op}, 8 / cw, cw);
    if (nb > 0) host.send({24'h0, d}, 8 / cw, cw);
    host.stop();
  endtask

  // Read frame: opcode, address, dummy clocks, nb bytes on w lanes
  task automatic rd(input logic [7:0] op, input logic [31:0] x, input int ab,
                    input int dm, input int w, input int nb,
                    output logic [31:0] d);
    int cw;
    cw = quad ? 4 : 1;
    host.start();
    host.send({24'h0, op}, 8 / cw, cw);
    if (ab > 0) host.send(x, ab / cw, cw);
    if (dm > 0) host.send(32'h0, dm, 0);
    host.recv(nb, w, d);
    host.stop();
    check(io_oe, 4'h0, "lanes released");
    check(areq.req, 1'b0, "array request ended");
  endtask

  // Cycle count cuts a hang short; sticky flags watch the outputs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (|io_oe) oe_seen <= 1'b1;
    if (wrap) wrap_seen <= 1'b1;
    if (cycles == 40000) begin
      n_fail++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end

  initial begin
    void'($urandom(32'hFE10));
    oe_seen = 1'b0;
    wrap_seen = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    // Upper byte register access and write enable gate
    check(uab, UAB_RESET, "upper byte reset");
    rd(OP_READ_UAB, 0, 0, 0, 1, 1, got);
    check(got, 32'h0, "upper byte read");
    ua = 8'h80 | 8'($urandom);
    cmd(OP_WRITE_UAB, ua, 8);
    check(uab, 8'h00, "write without latch");
    cmd(OP_WRITE_ENABLE, 0, 0);
    check(write_enable_latch, 1'b1, "latch set");
    cmd(OP_WRITE_UAB, ua, 8);
    check(write_enable_latch, 1'b0, "latch spent by write");
    rd(OP_READ_UAB, 0, 0, 0, 1, 1, got);
    check(got, ua, "upper byte written");
    done("upper byte");
    // Every read kind, narrow then wide addressing
    for (int m = 0; m < 2; m++) begin
      if (m == 1) begin
        cmd(OP_ENTER_WIDE, 0, 0);
        check(address_width_select, 1'b1, "enter wide");
      end
      for (int k = 0; k < 6; k++) begin
        a = $urandom & 32'hFFFF_FF7F;
        abits = (m == 1 || k >= 3) ? 32 : 24;
        ea = (abits == 24) ? {ua, a[23:0]} : a;
        host.half = (k == 1) ? 60.0 : 24.0;
        rd(ops[k], a, abits, (k % 3 == 0) ? 0 : 8, (k % 3 == 2) ? 2 : 1, 3,
           got);
        check(got, exp_bytes(ea, 3), "read stream");
        if (m == 1) ua = a[31:24];
        check(uab, ua, "upper byte after read");
      end
    end
    cmd(OP_EXIT_WIDE, 0, 0);
    check(address_width_select, 1'b0, "exit wide");
    rd(OP_READ_UAB, 0, 0, 0, 1, 1, got);
    check(got, ua, "upper byte recheck");
    done("address width");
    // Reads refused while an internal cycle runs
    @(negedge clk);
    busy = 1'b1;
    oe_seen = 1'b0;
    rd(OP_READ, a, 24, 0, 1, 1, got);
    check(oe_seen, 1'b0, "busy read");
    @(negedge clk);
    busy = 1'b0;
    // Reset pulse clears the volatile upper byte
    soft_rst = 1'b1;
    @(negedge clk);
    soft_rst = 1'b0;
    ua = UAB_RESET;
    check(uab, ua, "soft reset");
    done("busy and reset");
    // Quad command mode: refusals, wrap decode, dummy settings
    quad = 1'b1;
    check(wrap_seen, 1'b0, "no wrap in spi");
    oe_seen = 1'b0;
    rd(OP_READ_W32, a, 32, 0, 1, 1, got);
    check(oe_seen, 1'b0, "wide read refused in quad");
    cmd(OP_FAST_W32, 0, 0);
    check(wrap_seen, 1'b1, "wrap burst");
    for (int p = 0; p < 6; p++) begin
      if (p == 5) begin
        cmd(OP_RESET_ENABLE, 0, 0);
        cmd(OP_RESET, 0, 0);
      end else if (p > 0) begin
        cmd(OP_SET_PARAM, 8'(p - 1) << PARAM_DUMMY_LSB, 8);
      end
      dum = (p == 0 || p == 5) ? 2 : 2 * p;
      a = $urandom & 32'h00FF_FF7F;
      rd(OP_FAST, a, 24, dum, 4, 2, got);
      check(got, exp_bytes({ua, a[23:0]}, 2), "quad fast read");
    end
    quad = 1'b0;
    done("quad mode");
    end_sim();
  end
endmodule // serial_flash_read_addressing_tb

/* File: rtl/flash_cmd_pkg.sv */
// Package: opcodes, field layouts, reset values for the flash read decoder
package flash_cmd_pkg;
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_UAB = 8'hC8;
  localparam logic [7:0] OP_WRITE_UAB = 8'hC5;
  localparam logic [7:0] OP_ENTER_WIDE = 8'hB7;
  localparam logic [7:0] OP_EXIT_WIDE = 8'hE9;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ_W32 = 8'h13;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_FAST_W32 = 8'h0C;
  localparam logic [7:0] OP_DUAL = 8'h3B;
  localparam logic [7:0] OP_DUAL_W32 = 8'h3C;
  localparam logic [7:0] OP_SET_PARAM = 8'hC0;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  // Reset values
  localparam logic [7:0] UAB_RESET = 8'h00;
  localparam logic [1:0] DUMMY_SEL_RESET = 2'h0;
  // Read-parameter field position P[5:4]
  localparam int PARAM_DUMMY_LSB = 4;
  // Counts
  localparam logic [5:0] SPI_DUMMY_CLKS = 6'h08;
  localparam logic [5:0] BITS_24 = 6'h18;
  localparam logic [5:0] BITS_32 = 6'h20;
  localparam logic [5:0] BITS_BYTE = 6'h08;
  localparam logic [5:0] BITS_NIBBLE = 6'h04;
  localparam logic [5:0] DUAL_BYTE_CLKS = 6'h04;
  // Decoder phases
  typedef enum logic [2:0] {
    PH_OPCODE = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b010,
    PH_DATA = 3'b011,
    PH_REG_OUT = 3'b100,
    PH_REG_IN = 3'b101,
    PH_IGNORE = 3'b110
  } phase_t;
  // Read kind travelling with the command
  typedef struct packed {
    logic dual;
    logic fast;
    logic wide;
  } read_kind_t;
  // Array request toward memory core
  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } array_req_t;
endpackage

/* File: rtl/flash_read_decoder.sv */
// Command decoder for address width, upper address byte and array reads
//
// Functional notes
// - Narrow mode: upper byte supplies A[31:24]
// - Upper-byte read returns register MSB first
// - Wide mode ignores upper byte register
// - Upper-byte write needs write enable latch
// - Upper byte clears on power-up and reset
// - Wide mode: address top byte overwrites register
// - Enter opcode selects 32-bit addressing
// - Exit opcode returns to 24-bit addressing
// - Normal read: opcode, address, then data
// - Address increments per byte, streams on
// - Reads ignored while busy flag set
// - Opcode 13h always takes 32-bit address
// - Always-32-bit reads only in SPI mode
// - SPI fast read has eight dummy clocks
// - Quad dummy count from read parameters
// - Quad dummy count defaults to two
// - Opcode 0Ch is wrap burst in quad
// - Dual read: eight dummies, two lanes
// - Opcode 3Ch always takes 32-bit address
// - Dual lanes: odd on one, even zero
// - Write enable sets the latch
// - Quad mode moves four bits per clock
`timescale 1ns/100ps
module flash_read_decoder
  import flash_cmd_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE,
  input wire logic QUAD_COMMAND_MODE,
  input wire logic BUSY,
  input wire logic SOFT_RESET,
  output logic WRITE_ENABLE_LATCH,
  output logic ADDRESS_WIDTH_SELECT,
  output logic [7:0] UPPER_ADDRESS_BYTE,
  output array_req_t ARRAY_REQ,
  input wire logic [7:0] ARRAY_DATA,
  output logic WRAP_BURST_START
);
  // Synchronised pins: bit0 SCLK, bit1 select active, bits 5:2 lanes
  // Select is inverted first so its idle level matches the reset zero
  logic [5:0] pin_level;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;
  pin_edge_sync #(.WIDTH(6)) u_sync (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .din({IO_IN, !CS_N, SCLK}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );
  logic sck_rise; // Sample edge
  logic sck_fall; // Launch edge
  logic cs_active; // Frame in progress
  logic [3:0] lanes_in; // Synchronised lanes
  assign sck_rise = pin_rise[0] && pin_level[1];
  assign sck_fall = pin_fall[0] && pin_level[1];
  assign cs_active = pin_level[1];
  assign lanes_in = pin_level[5:2];
  logic cs_end; // Chip select rising
  assign cs_end = pin_fall[1];

  phase_t phase; // Decoder phase
  logic [7:0] opcode; // Latched command
  logic [31:0] shreg; // Incoming shift register
  logic [5:0] count; // Bits or clocks left in phase
  read_kind_t kind; // Current read flavour
  logic [31:0] addr; // Running array address
  logic [7:0] out_byte; // Byte being shifted out
  logic [5:0] out_cnt; // Clocks left in output byte
  logic [1:0] dummy_sel; // Quad dummy select P[5:4]
  logic reset_armed; // Reset enable seen
  logic drive; // Device owns output lanes

  // Bits taken per clock: 4 in quad mode, else 1
  function automatic logic [5:0] step(input logic quad);
    step = quad ? 6'h04 : 6'h01;
  endfunction
  // Shift new lane bits into the register
  function automatic logic [31:0] shift_in(input logic [31:0] r,
                                           input logic quad,
                                           input logic [3:0] l);
    shift_in = quad ? {r[27:0], l} : {r[30:0], l[0]};
  endfunction
  // Quad dummy clock count from two-bit field
  function automatic logic [5:0] quad_dummies(input logic [1:0] sel);
    quad_dummies = {3'h0, sel, 1'b0} + 6'h02;
  endfunction

  // Command decode helpers
  logic [7:0] next_op; // Opcode completed this edge
  logic op_done; // Opcode phase finishes now
  logic is_read; // Completed opcode is an array read
  logic is_w32_op; // Always-32-bit variant
  logic [31:0] shifted; // Shift register with this edge's lanes
  assign shifted = shift_in(shreg, QUAD_COMMAND_MODE, lanes_in);
  assign next_op = shifted[7:0];
  assign op_done = sck_rise && phase == PH_OPCODE
                   && count <= step(QUAD_COMMAND_MODE);
  assign is_w32_op = next_op == OP_READ_W32 || next_op == OP_DUAL_W32
                     || next_op == OP_FAST_W32;
  assign is_read = next_op == OP_READ || next_op == OP_FAST
                   || next_op == OP_DUAL || is_w32_op;

  // Main decoder sequence
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      phase <= PH_OPCODE;
      opcode <= 8'h00;
      shreg <= 32'h0;
      count <= BITS_BYTE;
      kind <= '0;
      addr <= 32'h0;
    end else if (!cs_active) begin
      // Idle between frames: ready for opcode
      phase <= PH_OPCODE;
      count <= BITS_BYTE;
      shreg <= 32'h0;
    end else if (sck_rise) begin
      shreg <= shift_in(shreg, QUAD_COMMAND_MODE, lanes_in);
      count <= count - step(QUAD_COMMAND_MODE);
      unique case (phase)
        PH_OPCODE: begin
          if (op_done) begin
            opcode <= next_op;
            kind <= '{dual: next_op == OP_DUAL || next_op == OP_DUAL_W32,
                      fast: next_op != OP_READ && next_op != OP_READ_W32,
                      wide: is_w32_op};
            if (is_read && BUSY) begin
              phase <= PH_IGNORE;
            end else if (is_w32_op && QUAD_COMMAND_MODE) begin
              phase <= PH_IGNORE;
            end else if (is_read && !(next_op == OP_DUAL
                         && QUAD_COMMAND_MODE)) begin
              phase <= PH_ADDR;
              // Width fixed at 32 for W32 variants
              count <= (is_w32_op || ADDRESS_WIDTH_SELECT) ? BITS_32
                       : BITS_24;
            end else if (next_op == OP_READ_UAB) begin
              phase <= PH_REG_OUT;
            end else if (next_op == OP_WRITE_UAB
                         && WRITE_ENABLE_LATCH) begin
              phase <= PH_REG_IN;
              count <= BITS_BYTE;
            end else if (next_op == OP_SET_PARAM) begin
              phase <= PH_REG_IN;
              count <= BITS_BYTE;
            end else begin
              phase <= PH_IGNORE;
            end
          end
        end
        PH_ADDR: begin
          if (count <= step(QUAD_COMMAND_MODE)) begin
            // Narrow address takes upper byte as top
            addr <= (kind.wide || ADDRESS_WIDTH_SELECT) ? shifted
                    : {UPPER_ADDRESS_BYTE,
                       shifted[23:0]};
            if (kind.fast) begin
              phase <= PH_DUMMY;
              count <= (QUAD_COMMAND_MODE && !kind.dual)
                       ? quad_dummies(dummy_sel)
                       : SPI_DUMMY_CLKS;
            end else begin
              phase <= PH_DATA;
            end
          end
        end
        PH_DUMMY: begin
          // Lane values ignored here; counts clocks only
          count <= count - 6'h01;
          if (count == 6'h01) begin
            phase <= PH_DATA;
          end
        end
        PH_REG_IN: begin
          if (count <= step(QUAD_COMMAND_MODE)) begin
            phase <= PH_IGNORE;
          end
        end
        default: begin
          // Data, register out and ignore run to chip select
        end
      endcase
      // Stream address advance on each byte boundary
      if (phase == PH_DATA && out_cnt == 6'h00) begin
        addr <= addr + 32'h1;
      end
    end
  end

  // Byte available for the data and register-out phases
  logic load_byte; // Start of a new output byte
  assign load_byte = sck_fall && (phase == PH_DATA || phase == PH_REG_OUT)
                     && out_cnt == 6'h00;
  // Output shifting on falling clock edges
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      out_byte <= 8'h00;
      out_cnt <= 6'h00;
      drive <= 1'b0;
    end else if (!cs_active) begin
      out_cnt <= 6'h00;
      drive <= 1'b0;
    end else if (load_byte) begin
      drive <= 1'b1;
      out_byte <= (phase == PH_REG_OUT) ? UPPER_ADDRESS_BYTE
                  : ARRAY_DATA;
      out_cnt <= (kind.dual && phase == PH_DATA) ? DUAL_BYTE_CLKS - 6'h01
                 : (QUAD_COMMAND_MODE ? 6'h01 : BITS_BYTE - 6'h01);
    end else if (sck_fall && out_cnt != 6'h00) begin
      out_cnt <= out_cnt - 6'h01;
      if (kind.dual && phase == PH_DATA) begin
        out_byte <= {out_byte[5:0], 2'b00};
      end else if (QUAD_COMMAND_MODE) begin
        out_byte <= {out_byte[3:0], 4'h0};
      end else begin
        out_byte <= {out_byte[6:0], 1'b0};
      end
    end
  end

  // Lane drivers: MSB first, pairs for dual, nibbles for quad
  always_comb begin
    IO_OUT = 4'h0;
    IO_OE = 4'h0;
    if (drive) begin
      if (kind.dual && phase == PH_DATA) begin
        IO_OUT = {2'b00, out_byte[7], out_byte[6]};
        IO_OE = 4'h3;
      end else if (QUAD_COMMAND_MODE) begin
        IO_OUT = out_byte[7:4];
        IO_OE = 4'hF;
      end else begin
        IO_OUT = {2'b00, out_byte[7], 1'b0};
        IO_OE = 4'h2;
      end
    end
  end
  assign ARRAY_REQ = '{req: phase == PH_DATA, addr: addr};

  // Register write completion on last rising edge
  logic reg_done; // Data byte fully received
  logic [7:0] reg_byte; // Received byte
  assign reg_done = sck_rise && phase == PH_REG_IN
                    && count <= step(QUAD_COMMAND_MODE);
  assign reg_byte = shifted[7:0];
  logic hard_reset; // Reset command completes, or soft reset pulse
  assign hard_reset = (cs_end && opcode == OP_RESET && reset_armed)
                      || SOFT_RESET;

  // Upper address byte register
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      UPPER_ADDRESS_BYTE <= UAB_RESET;
    end else if (hard_reset) begin
      UPPER_ADDRESS_BYTE <= UAB_RESET;
    end else if (reg_done && opcode == OP_WRITE_UAB) begin
      UPPER_ADDRESS_BYTE <= reg_byte;
    end else if (sck_rise && phase == PH_ADDR && ADDRESS_WIDTH_SELECT
                 && count <= step(QUAD_COMMAND_MODE)) begin
      UPPER_ADDRESS_BYTE <= shifted[31:24];
    end
  end

  // Address width, write enable latch, read parameters
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ADDRESS_WIDTH_SELECT <= 1'b0;
      WRITE_ENABLE_LATCH <= 1'b0;
      dummy_sel <= DUMMY_SEL_RESET;
      reset_armed <= 1'b0;
    end else if (hard_reset) begin
      ADDRESS_WIDTH_SELECT <= 1'b0;
      WRITE_ENABLE_LATCH <= 1'b0;
      dummy_sel <= DUMMY_SEL_RESET;
      reset_armed <= 1'b0;
    end else begin
      if (cs_end && phase == PH_IGNORE) begin
        // Opcode-only commands act at chip select rise
        if (opcode == OP_ENTER_WIDE) begin
          ADDRESS_WIDTH_SELECT <= 1'b1;
        end
        if (opcode == OP_EXIT_WIDE) begin
          ADDRESS_WIDTH_SELECT <= 1'b0;
        end
        if (opcode == OP_WRITE_ENABLE) begin
          WRITE_ENABLE_LATCH <= 1'b1;
        end
        reset_armed <= opcode == OP_RESET_ENABLE;
      end
      if (reg_done && opcode == OP_WRITE_UAB) begin
        WRITE_ENABLE_LATCH <= 1'b0;
      end
      if (reg_done && opcode == OP_SET_PARAM) begin
        dummy_sel <= reg_byte[PARAM_DUMMY_LSB +: 2];
      end
    end
  end

  // Quad mode 0Ch starts wrap burst in another block
  assign WRAP_BURST_START = op_done && QUAD_COMMAND_MODE
                            && next_op == OP_FAST_W32;

  chk_busy_read: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    op_done && is_read && BUSY |=> phase == PH_IGNORE)
    else $error("read taken while busy");
  chk_quad_w32: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    op_done && QUAD_COMMAND_MODE && next_op == OP_READ_W32
    |=> phase == PH_IGNORE)
    else $error("32-bit read accepted in quad mode");
  chk_cs_release: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    !cs_active |=> IO_OE == 4'h0 && phase == PH_OPCODE)
    else $error("lanes driven after chip select high");
  chk_wide_width: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    op_done && next_op == OP_READ_W32 && !BUSY && !QUAD_COMMAND_MODE
    |=> count == BITS_32)
    else $error("13h not given 32-bit address");
  chk_uab_guard: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    op_done && next_op == OP_WRITE_UAB && !WRITE_ENABLE_LATCH
    |=> phase == PH_IGNORE)
    else $error("upper byte write without latch");
  chk_enter_wide: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    cs_end && phase == PH_IGNORE && opcode == OP_ENTER_WIDE
    && !hard_reset |=> ADDRESS_WIDTH_SELECT)
    else $error("wide mode not entered");
  chk_exit_wide: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    cs_end && phase == PH_IGNORE && opcode == OP_EXIT_WIDE
    |=> !ADDRESS_WIDTH_SELECT)
    else $error("wide mode not left");
  chk_spi_dummy: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(phase == PH_DUMMY) && !QUAD_COMMAND_MODE
    |-> count == SPI_DUMMY_CLKS)
    else $error("SPI dummy count not eight");
  chk_dual_lanes: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    drive && kind.dual && phase == PH_DATA |-> IO_OE == 4'h3)
    else $error("dual data not on two lanes");
endmodule // flash_read_decoder

/* File: rtl/pin_edge_sync.sv */
// Three-stage synchroniser with rise and fall detection
`timescale 1ns/100ps
module pin_edge_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] s1; // Metastable stage, read only by s2
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] stable; // Filtered level
  // Shift chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // A change counts once s2 and s3 agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stable <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) begin
          stable[i] <= s3[i];
        end
      end
    end
  end
  // Edges of the filtered level
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      rise[i] = !stable[i] && (s2[i] == s3[i]) && s3[i];
      fall[i] = stable[i] && (s2[i] == s3[i]) && !s3[i];
    end
  end
  assign level = stable;
endmodule // pin_edge_sync
